// >>> core/dag_defs.svh
// Constants for the diagnostic alert gating block
`ifndef DAG_DEFS_SVH
`define DAG_DEFS_SVH

// ****************************************
// Sizes
// ****************************************
`define DAG_NUM_ALERTS 19
`define DAG_NUM_CAT 4
`define DAG_NUM_CLS 3
`define DAG_PRI_W 4
`define DAG_TMR_W 24
`define DAG_ADDR_W 8
`define DAG_DATA_W 32

// ****************************************
// Register offsets
// ****************************************
`define DAG_OFF_CTRL 8'h00
`define DAG_OFF_COND_EN 8'h04
`define DAG_OFF_CAT_BASE 8'h08
`define DAG_OFF_PRIO 8'h18
`define DAG_OFF_MASK_BASE 8'h1C
`define DAG_OFF_SIM 8'h28
`define DAG_OFF_ACK_TMO 8'h2C
`define DAG_OFF_ACTIVE 8'h30
`define DAG_OFF_REP_BASE 8'h34
`define DAG_OFF_NOTIFY 8'h40
`define DAG_OFF_STRIDE 8'h04
`define DAG_IDX_SHIFT 2

// ****************************************
// Fields
// ****************************************
`define DAG_CTRL_REPORT_BIT 0
`define DAG_CTRL_SETSTAT_BIT 1
`define DAG_NOTIFY_SIM_POS 6
`define DAG_NOTIFY_RB_POS 9

// ****************************************
// Categories and simulation priority
// ****************************************
`define DAG_CAT_FAILED 2'h0
`define DAG_CAT_FCHECK 2'h1
`define DAG_CAT_OFFSPEC 2'h2
`define DAG_CAT_MAINT 2'h3
`define DAG_PRI_SIM 4'h1

// Alerts that need automatic mode
`define DAG_AUTO_MASK 19'h7FE23

// ****************************************
// Reset values
// ****************************************
`define DAG_RST_CTRL 2'h0
`define DAG_RST_COND_EN 19'h7FFFF
`define DAG_RST_VEC 19'h00000
`define DAG_RST_ACK_TMO 24'h0F4240

`endif

// >>> core/dag_pkg.sv
// Types for the diagnostic alert gating block
`include "dag_defs.svh"
package dag_pkg;

	typedef struct packed {
		logic isAuto;
		logic isOos;
		logic shutdownActive;
		logic shutdownLatched;
	} dag_mode_t;

	typedef struct packed {
		logic [1:0] alertClass;
		logic [`DAG_PRI_W-1:0] prio;
		logic [`DAG_NUM_ALERTS-1:0] alerts;
	} dag_notify_t;

	typedef enum logic [1:0] {
		DAG_IDLE,
		DAG_PEND,
		DAG_WAIT
	} dag_notify_state_t;

endpackage : dag_pkg

// >>> core/dag_alert_gating.sv
// Alert qualification, legacy class mapping and acknowledged notification
`timescale 1ns/100ps
`include "dag_defs.svh"

// Summary of operation
// - A disabled alert condition is never checked and never raises an alert.
// - Alert active needs condition enabled, a category, and either present and mode qualified or simulated.
// - Each alert is assignable to any of four categories by configuration.
// - Each notification is resent on timeout until the host acknowledges it.
// - Failed maps to failed, offspec to maintenance, maintenance to advisory.
// - Technician-triggerable alerts, unless simulated, report only while the block mode is automatic or a shutdown is present or latched.
// - Alerts unrelated to technician activity report in every block mode.
// - Simulated alerts skip mode qualification but still need their enable.
// - A present or latched shutdown lets alerts report even out of service.
// - Drive, travel, supply, temperature limit, counters, performance, fallback need automatic.
// - Processor, timeout, defaults and the three sensor alerts qualify in any mode.
// - Report needs active, reporting selected, priority above one, and not suppressed.
// - Priority zero disables all reporting for that class.
// - Priority one simulates the report inside, with nothing sent out.
// - Priorities two to fifteen send; a higher priority is sent first.
// - Per-class suppression masks withhold chosen alert conditions from reporting.
// - Active alerts may set readback status, governed by a set-status control.
module dag_alert_gating #(
	parameter logic [`DAG_TMR_W-1:0] ACK_TIMEOUT_DEFAULT = `DAG_RST_ACK_TMO
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [`DAG_ADDR_W-1:0] regAddr,
	input wire logic [`DAG_DATA_W-1:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output logic [`DAG_DATA_W-1:0] regRdData,
	input wire logic [`DAG_NUM_ALERTS-1:0] condExists,
	input wire dag_pkg::dag_mode_t blockMode,
	input wire logic simulateEnable,
	input wire logic [`DAG_NUM_CLS-1:0] ackToggle,
	output logic notifyValid,
	output dag_pkg::dag_notify_t notifyData,
	output logic [`DAG_NUM_CLS-1:0] readbackStatus
);

	localparam int NA = `DAG_NUM_ALERTS;
	localparam int NC = `DAG_NUM_CLS;
	localparam int NK = `DAG_NUM_CAT;
	localparam int PW = `DAG_PRI_W;
	localparam int TW = `DAG_TMR_W;

	// ****************************************
	// Functions
	// ****************************************
	// Category feeding each legacy class
	function automatic logic [1:0] clsCat(input int cls);
		logic [1:0] cat;
		cat = `DAG_CAT_FAILED;
		if (cls == 1) begin
			cat = `DAG_CAT_OFFSPEC;
		end else if (cls == 2) begin
			cat = `DAG_CAT_MAINT;
		end
		return cat;
	endfunction : clsCat

	// Highest priority pending class, lowest index on a tie
	function automatic logic [2:0] pickClass(input logic [NC-1:0] pend,
		input logic [NC-1:0][PW-1:0] pri);
		logic [1:0] best;
		logic found;
		logic [PW-1:0] bestPri;
		best = 2'h0;
		found = 1'b0;
		bestPri = '0;
		for (int i = 0; i < NC; i++) begin
			if (pend[i] && (!found || pri[i] > bestPri)) begin
				best = 2'(i);
				found = 1'b1;
				bestPri = pri[i];
			end
		end
		return {found, best};
	endfunction : pickClass

	// Word index of an address inside a register group
	function automatic logic [`DAG_ADDR_W-1:0] grpIdx(input logic [`DAG_ADDR_W-1:0] a,
		input logic [`DAG_ADDR_W-1:0] base);
		logic [`DAG_ADDR_W-1:0] d;
		d = a - base;
		return d >> `DAG_IDX_SHIFT;
	endfunction : grpIdx

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [NA-1:0] condMeta;
	logic [NA-1:0] condSync;
	dag_pkg::dag_mode_t modeMeta;
	dag_pkg::dag_mode_t modeSync;
	logic simMeta;
	logic simSync;
	logic [NC-1:0] ackMeta;
	logic [NC-1:0] ackSync;
	logic [NC-1:0] ackPrev;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			condMeta <= '0;
			condSync <= '0;
			modeMeta <= '0;
			modeSync <= '0;
			simMeta <= 1'b0;
			simSync <= 1'b0;
			ackMeta <= '0;
			ackSync <= '0;
			ackPrev <= '0;
		end else begin
			condMeta <= condExists;
			condSync <= condMeta;
			modeMeta <= blockMode;
			modeSync <= modeMeta;
			simMeta <= simulateEnable;
			simSync <= simMeta;
			ackMeta <= ackToggle;
			ackSync <= ackMeta;
			ackPrev <= ackSync;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	logic [1:0] ctrl_reg;
	logic [NA-1:0] condEnable_reg;
	logic [NK-1:0][NA-1:0] catEn_reg;
	logic [NC-1:0][PW-1:0] pri_reg;
	logic [NC-1:0][NA-1:0] mask_reg;
	logic [NA-1:0] simAlert_reg;
	logic [TW-1:0] ackTimeout_reg;

	wire catIn = regAddr >= `DAG_OFF_CAT_BASE && regAddr < `DAG_OFF_PRIO;
	wire maskIn = regAddr >= `DAG_OFF_MASK_BASE && regAddr < `DAG_OFF_SIM;
	wire repIn = regAddr >= `DAG_OFF_REP_BASE && regAddr < `DAG_OFF_NOTIFY;
	wire [`DAG_ADDR_W-1:0] catIdx = grpIdx(regAddr, `DAG_OFF_CAT_BASE);
	wire [`DAG_ADDR_W-1:0] maskIdx = grpIdx(regAddr, `DAG_OFF_MASK_BASE);
	wire [`DAG_ADDR_W-1:0] repIdx = grpIdx(regAddr, `DAG_OFF_REP_BASE);
	wire wrCtrl = regWrStrobe && regAddr == `DAG_OFF_CTRL;
	wire wrCond = regWrStrobe && regAddr == `DAG_OFF_COND_EN;
	wire wrCat = regWrStrobe && catIn;
	wire wrPri = regWrStrobe && regAddr == `DAG_OFF_PRIO;
	wire wrMask = regWrStrobe && maskIn;
	wire wrSim = regWrStrobe && regAddr == `DAG_OFF_SIM;
	wire wrTmo = regWrStrobe && regAddr == `DAG_OFF_ACK_TMO;
	wire reportSel = ctrl_reg[`DAG_CTRL_REPORT_BIT];
	wire setStatus = ctrl_reg[`DAG_CTRL_SETSTAT_BIT];

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= `DAG_RST_CTRL;
			condEnable_reg <= `DAG_RST_COND_EN;
			simAlert_reg <= `DAG_RST_VEC;
			ackTimeout_reg <= ACK_TIMEOUT_DEFAULT;
			pri_reg <= '0;
		end else begin
			if (wrCtrl) begin
				ctrl_reg <= regWrData[1:0];
			end
			if (wrCond) begin
				condEnable_reg <= regWrData[NA-1:0];
			end
			if (wrSim) begin
				simAlert_reg <= regWrData[NA-1:0];
			end
			if (wrTmo) begin
				ackTimeout_reg <= regWrData[TW-1:0];
			end
			if (wrPri) begin
				pri_reg <= regWrData[NC*PW-1:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			catEn_reg <= '0;
			mask_reg <= '0;
		end else begin
			if (wrCat) begin
				catEn_reg[catIdx[1:0]] <= regWrData[NA-1:0];
			end
			if (wrMask) begin
				mask_reg[maskIdx[1:0]] <= regWrData[NA-1:0];
			end
		end
	end

	// ****************************************
	// Alert qualification
	// ****************************************
	wire [NA-1:0] condChecked = condSync & condEnable_reg;
	wire [NA-1:0] simSel = simAlert_reg & {NA{simSync}};
	wire [NA-1:0] anyCat = catEn_reg[0] | catEn_reg[1] | catEn_reg[2] | catEn_reg[3];
	wire shutdownHeld = modeSync.shutdownActive | modeSync.shutdownLatched;
	wire autoOk = modeSync.isAuto | shutdownHeld;
	wire [NA-1:0] modeOk = ~`DAG_AUTO_MASK | {NA{autoOk}};
	wire [NA-1:0] activeNext = condEnable_reg & anyCat & ((condChecked & modeOk) | simSel);
	logic [NA-1:0] active_reg;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			active_reg <= '0;
		end else begin
			active_reg <= activeNext;
		end
	end

	// ****************************************
	// Per-class reporting and notifiers
	// ****************************************
	logic [NC-1:0][NA-1:0] reported;
	logic [NC-1:0] simRep;
	logic [NC-1:0] pendVec;
	logic [NC-1:0] rbNext;
	logic [NC-1:0][1:0] stateVec;
	wire [2:0] pick = pickClass(pendVec, pri_reg);
	wire pickValid = pick[2];
	wire [1:0] pickIdx = pick[1:0];

	generate
		for (genvar c = 0; c < NC; c++) begin : g_cls
			dag_pkg::dag_notify_state_t state_reg;
			dag_pkg::dag_notify_state_t state_next;
			logic [TW-1:0] timer_reg;
			logic [TW-1:0] timer_next;
			logic [NA-1:0] repPrev_reg;
			wire [NA-1:0] catSel = catEn_reg[clsCat(c)];
			wire [NA-1:0] cand = active_reg & catSel & ~mask_reg[c] & {NA{reportSel}};
			wire priReal = pri_reg[c] > `DAG_PRI_SIM;
			wire newRep = |(reported[c] & ~repPrev_reg);
			wire ackSeen = ackSync[c] ^ ackPrev[c];
			wire grant = pickValid && pickIdx == 2'(c);
			wire timeout = state_reg == dag_pkg::DAG_WAIT && timer_reg == '0;

			assign reported[c] = priReal ? cand : '0;
			assign simRep[c] = pri_reg[c] == `DAG_PRI_SIM && |cand;
			assign pendVec[c] = state_reg == dag_pkg::DAG_PEND;
			assign stateVec[c] = state_reg;
			assign rbNext[c] = setStatus & |(active_reg & catSel);

			// New alert outranks an acknowledge, an acknowledge outranks a timeout
			always_comb begin
				state_next = state_reg;
				unique case (state_reg)
					dag_pkg::DAG_IDLE: begin
						if (newRep) state_next = dag_pkg::DAG_PEND;
					end
					dag_pkg::DAG_PEND: begin
						if (grant) state_next = dag_pkg::DAG_WAIT;
					end
					dag_pkg::DAG_WAIT: begin
						if (newRep || (timeout && !ackSeen)) begin
							state_next = dag_pkg::DAG_PEND;
						end else if (ackSeen) begin
							state_next = dag_pkg::DAG_IDLE;
						end
					end
					default: begin
						state_next = dag_pkg::DAG_IDLE;
					end
				endcase
			end

			assign timer_next = grant ? ackTimeout_reg :
				ackSeen ? '0 :
				(state_reg == dag_pkg::DAG_WAIT && timer_reg != '0) ? timer_reg - 1'b1 :
				timer_reg;

			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					state_reg <= dag_pkg::DAG_IDLE;
					timer_reg <= '0;
					repPrev_reg <= '0;
				end else begin
					state_reg <= state_next;
					timer_reg <= timer_next;
					repPrev_reg <= reported[c];
				end
			end
		end
	endgenerate

	// ****************************************
	// Notification output
	// ****************************************
	logic notifyValid_reg;
	dag_pkg::dag_notify_t notifyData_reg;
	logic [NC-1:0] readback_reg;
	wire dag_pkg::dag_notify_t notifyNext = '{alertClass: pickIdx,
		prio: pri_reg[pickIdx], alerts: reported[pickIdx]};

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			notifyValid_reg <= 1'b0;
			notifyData_reg <= '0;
			readback_reg <= '0;
		end else begin
			notifyValid_reg <= pickValid;
			if (pickValid) begin
				notifyData_reg <= notifyNext;
			end
			readback_reg <= rbNext;
		end
	end

	assign notifyValid = notifyValid_reg;
	assign notifyData = notifyData_reg;
	assign readbackStatus = readback_reg;

	// ****************************************
	// Register read
	// ****************************************
	wire [`DAG_DATA_W-1:0] notifyWord = `DAG_DATA_W'({readback_reg, simRep, stateVec});
	wire [`DAG_DATA_W-1:0] rdMux =
		regAddr == `DAG_OFF_CTRL ? `DAG_DATA_W'(ctrl_reg) :
		regAddr == `DAG_OFF_COND_EN ? `DAG_DATA_W'(condEnable_reg) :
		catIn ? `DAG_DATA_W'(catEn_reg[catIdx[1:0]]) :
		regAddr == `DAG_OFF_PRIO ? `DAG_DATA_W'(pri_reg) :
		maskIn ? `DAG_DATA_W'(mask_reg[maskIdx[1:0]]) :
		regAddr == `DAG_OFF_SIM ? `DAG_DATA_W'(simAlert_reg) :
		regAddr == `DAG_OFF_ACK_TMO ? `DAG_DATA_W'(ackTimeout_reg) :
		regAddr == `DAG_OFF_ACTIVE ? `DAG_DATA_W'(active_reg) :
		repIn ? `DAG_DATA_W'(reported[repIdx[1:0]]) :
		regAddr == `DAG_OFF_NOTIFY ? notifyWord :
		'0;
	logic [`DAG_DATA_W-1:0] rdData_reg;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData_reg <= '0;
		end else begin
			rdData_reg <= regRdStrobe ? rdMux : '0;
		end
	end

	assign regRdData = rdData_reg;

endmodule : dag_alert_gating

// >>> verif/dag_alert_gating_monitor.sv
// Checker bound to the alert gating block
`timescale 1ns/100ps
`include "dag_defs.svh"
module dag_alert_gating_monitor (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	input wire logic [31:0] regRdData,
	input wire logic [18:0] condExists,
	input wire dag_pkg::dag_mode_t blockMode,
	input wire logic simulateEnable,
	input wire logic [2:0] ackToggle,
	input wire logic notifyValid,
	input wire dag_pkg::dag_notify_t notifyData,
	input wire logic [2:0] readbackStatus
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	wire modeOk = blockMode.isAuto | blockMode.shutdownActive | blockMode.shutdownLatched;
	property p_pri; notifyValid |-> notifyData[22:19] > 4'h1; endproperty
	a_pri: assert property (p_pri) else $error("send below priority two");
	property p_cls; notifyValid |-> notifyData[24:23] != 2'h3; endproperty
	a_cls: assert property (p_cls) else $error("send with bad class");
	property p_hold; !notifyValid |-> $stable(notifyData); endproperty
	a_hold: assert property (p_hold) else $error("notify data moved");
	property p_gap;
		notifyValid ##1 notifyValid |-> notifyData[24:23] != $past(notifyData[24:23]);
	endproperty
	a_gap: assert property (p_gap) else $error("class resent too soon");
	property p_idle;
		(condExists == 19'h0 && !simulateEnable)[*6] |-> readbackStatus == 3'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("status without alert");
	property p_mode;
		(!modeOk && (condExists & ~`DAG_AUTO_MASK) == 19'h0 && !simulateEnable)[*6]
			|-> readbackStatus == 3'h0;
	endproperty
	a_mode: assert property (p_mode) else $error("status outside auto");
	property p_rb;
		regWrStrobe && regAddr == 8'h00 && !regWrData[1] ##1 !regWrStrobe
			|=> readbackStatus == 3'h0;
	endproperty
	a_rb: assert property (p_rb) else $error("status while set off");
	property p_rd; regRdData != 32'h0 |-> $past(regRdStrobe); endproperty
	a_rd: assert property (p_rd) else $error("read data unasked");
endmodule : dag_alert_gating_monitor
bind dag_alert_gating dag_alert_gating_monitor mon_u (.core_clk(core_clk), .arst_n(arst_n),
	.regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
	.regRdStrobe(regRdStrobe), .regRdData(regRdData), .condExists(condExists),
	.blockMode(blockMode), .simulateEnable(simulateEnable), .ackToggle(ackToggle),
	.notifyValid(notifyValid), .notifyData(notifyData), .readbackStatus(readbackStatus));

// >>> verif/dag_host_model.sv
// Host model that acknowledges alert notifications
`timescale 1ns/100ps
module dag_host_model (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic notifyValid,
	input wire dag_pkg::dag_notify_t notifyData,
	input wire logic ackOn,
	output logic [2:0] ackToggle
);
	logic [2:0][2:0] waitReg;
	// ****
	// Acknowledge each class a few cycles after its send
	// ****
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ackToggle <= 3'h0;
			waitReg <= '0;
		end else begin
			for (int c = 0; c < 3; c++) begin
				if (notifyValid && ackOn && notifyData.alertClass == 2'(c)) begin
					waitReg[c] <= 3'h3;
				end else if (waitReg[c] == 3'h1) begin
					ackToggle[c] <= ~ackToggle[c];
					waitReg[c] <= 3'h0;
				end else if (waitReg[c] != 3'h0) begin
					waitReg[c] <= waitReg[c] - 3'h1;
				end
			end
		end
	end
endmodule : dag_host_model

// >>> verif/dag_alert_gating_bench.sv
// Self-checking bench for the alert gating block
`timescale 1ns/100ps
module dag_alert_gating_bench;
	logic core_clk, arst_n, regWrStrobe, regRdStrobe, simulateEnable, notifyValid, ackOn;
	logic [7:0] regAddr;
	logic [31:0] regWrData, regRdData;
	logic [18:0] condExists;
	logic [2:0] ackToggle, readbackStatus;
	dag_pkg::dag_mode_t blockMode;
	dag_pkg::dag_notify_t notifyData;
	int nChecks, miscompares;
	dag_alert_gating dut_u (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
		.regRdData(regRdData), .condExists(condExists), .blockMode(blockMode),
		.simulateEnable(simulateEnable), .ackToggle(ackToggle), .notifyValid(notifyValid),
		.notifyData(notifyData), .readbackStatus(readbackStatus));
	dag_host_model host_u (.core_clk(core_clk), .arst_n(arst_n), .notifyValid(notifyValid),
		.notifyData(notifyData), .ackOn(ackOn), .ackToggle(ackToggle));
	task wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wt
	task chk(input logic [31:0] g, input logic [31:0] e);
		nChecks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStrobe <= 1'b1;
		@(posedge core_clk);
		regWrStrobe <= 1'b0;
	endtask : wr
	task rdc(input logic [7:0] a, input logic [31:0] e, output logic [31:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		@(posedge core_clk);
		regRdStrobe <= 1'b0;
		@(posedge core_clk);
		v = regRdData;
		chk(v, e);
	endtask : rdc
	task wn(input int lim, output int c);
		c = 0;
		do begin
			@(posedge core_clk);
			c++;
		end while (c < lim && notifyValid !== 1'b1);
	endtask : wn
	task t_regs;
		logic [31:0] v;
		rdc(8'h04, 32'h0007FFFF, v);
		rdc(8'h2C, 32'h000F4240, v);
		wr(8'h30, 32'h0000000F);
		rdc(8'h30, 32'h0, v);
		rdc(8'h50, 32'h0, v);
		$display("done regs");
	endtask : t_regs
	task t_mode;
		logic [3:0] md [5] = '{4'h0, 4'h8, 4'h6, 4'h5, 4'h4};
		logic [18:0] b;
		logic [31:0] v;
		wr(8'h08, 32'h0007FFFF);
		for (int i = 0; i < 19; i++) begin
			b = 19'h1 << i;
			condExists <= b;
			foreach (md[j]) begin
				blockMode <= md[j];
				wt(4);
				rdc(8'h30, (md[j] & 4'hB) != 4'h0 ? b : b & ~`DAG_AUTO_MASK, v);
			end
		end
		condExists <= 19'h0;
		wr(8'h08, 32'h0);
		$display("done mode");
	endtask : t_mode
	task t_qual;
		logic [31:0] v;
		condExists <= 19'h4;
		for (int c = 0; c < 5; c++) begin
			for (int k = 0; k < 4; k++) wr(8'h08 + 8'(4 * k), k == c ? 32'h4 : 32'h0);
			rdc(8'h30, c < 4 ? 32'h4 : 32'h0, v);
		end
		wr(8'h08, 32'h5);
		wr(8'h04, 32'h0007FFFA);
		rdc(8'h30, 32'h0, v);
		condExists <= 19'h0;
		wr(8'h28, 32'h1);
		simulateEnable <= 1'b1;
		wt(4);
		rdc(8'h30, 32'h0, v);
		wr(8'h04, 32'h0007FFFF);
		rdc(8'h30, 32'h1, v);
		simulateEnable <= 1'b0;
		wt(4);
		rdc(8'h30, 32'h0, v);
		wr(8'h28, 32'h0);
		wr(8'h08, 32'h0);
		$display("done qualify");
	endtask : t_qual
	task t_report;
		logic [7:0] ca [3] = '{8'h08, 8'h10, 8'h14};
		logic [31:0] v;
		int n;
		blockMode <= 4'h8;
		ackOn <= 1'b1;
		for (int c = 0; c < 3; c++) begin
			wr(ca[c], 32'h4);
			for (int p = 0; p < 5; p++) begin
				condExists <= 19'h0;
				wr(8'h00, p < 4 ? 32'h1 : 32'h0);
				wr(8'h18, 32'(p > 2 ? 15 : p) << (4 * c));
				wr(8'h1C + 8'(4 * c), p == 3 ? 32'h4 : 32'h0);
				wt(4);
				condExists <= 19'h4;
				wn(12, n);
				chk(n < 12, p == 2);
				if (p == 2) chk(notifyData, {c[1:0], 4'h2, 19'h4});
				v = (p == 1) ? 32'h1 << (6 + c) : (p == 2) ? 32'h2 << (2 * c) : 32'h0;
				rdc(8'h40, v, v);
				chk(v[6 + c], p == 1);
			end
			wr(ca[c], 32'h0);
		end
		condExists <= 19'h0;
		$display("done report");
	endtask : t_report
	task t_retry;
		int n;
		ackOn <= 1'b0;
		wr(8'h00, 32'h1);
		wr(8'h18, 32'h2);
		wr(8'h08, 32'h4);
		condExists <= 19'h4;
		wn(12, n);
		condExists <= 19'h0;
		wn(40, n);
		chk(n, 32'h16);
		ackOn <= 1'b1;
		wn(40, n);
		chk(n, 32'h16);
		wn(40, n);
		chk(n, 32'h28);
		$display("done retry");
	endtask : t_retry
	task t_prec;
		int n;
		wr(8'h18, 32'h93);
		wr(8'h10, 32'h4);
		condExists <= 19'h4;
		wn(12, n);
		chk(notifyData[24:23], 2'h1);
		wn(3, n);
		chk(notifyData[24:23], 2'h0);
		wr(8'h00, 32'h3);
		wt(2);
		#1 chk(readbackStatus, 3'h3);
		wr(8'h00, 32'h1);
		wt(2);
		#1 chk(readbackStatus, 3'h0);
		$display("done priority");
	endtask : t_prec
	task summarize;
		$display("checks %0d mismatches %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#200000;
		miscompares++;
		summarize();
	end
	initial begin
		arst_n = 1'b0;
		{regWrStrobe, regRdStrobe, simulateEnable, ackOn} = 4'h0;
		regAddr = 8'h00;
		regWrData = 32'h0;
		condExists = 19'h0;
		blockMode = 4'h0;
		wt(5);
		arst_n <= 1'b1;
		t_regs();
		wr(8'h2C, 32'h14);
		t_mode();
		t_qual();
		t_report();
		t_retry();
		t_prec();
		summarize();
	end
endmodule : dag_alert_gating_bench
